/* File: test/sdram_model.sv */
`timescale 1ns/1ps
module sdram_model (
    input  wire logic       read_go,
    output logic            dqs,
    output logic      [7:0] dq,
    output logic            busy
);
    int i;
    // A released line shows the inverse of its last level, never a copy.
    initial begin
        dqs  = 1'b1;
        dq   = 8'h5a;
        busy = 1'b0;
    end
    always @(posedge read_go) begin
        busy = 1'b1;
        #7 dqs = 1'b0;
        #200;
        for (i = 0; i < 4; i++) begin
            dq  = dq + 8'h11;
            dqs = ~dqs;
            #200;
        end
        #200 dqs = 1'b1;
        dq   = ~dq;
        busy = 1'b0;
    end
endmodule : sdram_model

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`include "strobe_params.svh"
module tb_top;
    import strobe_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        ref_clk = 1'b0, sys_clk = 1'b0, wr_clk = 1'b0;
    logic        meas_up = 1'b0, meas_dn = 1'b0, read_go = 1'b0;
    logic        postamble_gate = 1'b0, write_active = 1'b0;
    logic        pready, pslverr, dqs_in, dqs_out, dqs_oe, dq_oe, busy;
    logic        shifted_strobe, strobe_bus;
    logic [7:0]  dq_in, dq_out, capt_h, capt_l;
    delay_t      dll_setting;
    int          num_errors = 0;
    int          samples_checked = 0;

    always #25 pclk = ~pclk;
    // Slow clocks toggle on falling pclk edges so sampling never races.
    always #200 ref_clk = ~ref_clk;
    always #200 sys_clk = ~sys_clk;
    initial begin
        #100;
        forever #200 wr_clk = ~wr_clk;
    end

    ddr_strobe_capture_path #(.DQ_WIDTH(8), .HIST_DEPTH(512)) dut_u (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dqs_in(dqs_in), .dqs_out(dqs_out), .dqs_oe(dqs_oe),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .ref_clk(ref_clk), .sys_clk(sys_clk), .wr_clk(wr_clk),
        .alt_oe_clk(~wr_clk), .meas_up(meas_up), .meas_dn(meas_dn),
        .postamble_gate(postamble_gate), .write_active(write_active),
        .shifted_strobe(shifted_strobe), .strobe_bus(strobe_bus),
        .dll_setting(dll_setting), .capt_h(capt_h), .capt_l(capt_l));
    sdram_model mem_u (.read_go(read_go), .dqs(dqs_in), .dq(dq_in),
                       .busy(busy));

    ////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test
    task automatic hang();
        num_errors++;
        finish_test();
    endtask : hang
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        int n;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) hang();
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic status_wait(input logic [31:0] m, input logic [31:0] v);
        logic [31:0] r;
        logic        e;
        int          n;
        n = 0;
        do begin
            apb(1'b0, `OFF_STATUS, 32'h0, r, e);
            n++;
        end while ((r & m) !== v && n < 300);
        if ((r & m) !== v) hang();
    endtask : status_wait
    // Measures from the preamble fall; idle high must first drain the chain.
    task automatic lag(output int n);
        int k;
        repeat (120) @(posedge pclk);
        read_go <= 1'b1;
        @(posedge pclk);
        read_go <= 1'b0;
        k = 0;
        while (dqs_in !== 1'b0 && k < 20) begin
            @(posedge pclk);
            k++;
        end
        n = 0;
        while (shifted_strobe !== 1'b0 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        if (k == 20 || n == 200) hang();
    endtask : lag

    ////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] r;
        logic        e;
        chk({dqs_oe, dq_oe, shifted_strobe, strobe_bus, pready}, 32'h3);
        chk(dll_setting, 32'h0);
        apb(1'b0, `OFF_CTRL, 32'h0, r, e);
        chk(r, `CTRL_RESET);
        wr(8'h20, 32'hffff);
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk({e, r[30:0]}, 32'h80000000);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_counter();
        int i;
        for (i = 0; i < 4; i++) begin
            @(posedge pclk);
            meas_up <= (i < 3);
            meas_dn <= (i == 3);
            @(posedge pclk);
            meas_up <= 1'b0;
            meas_dn <= 1'b0;
        end
        repeat (2) @(posedge pclk);
        chk(dll_setting, 32'h2);
        $display("t_counter done");
    endtask : t_counter
    task automatic t_latch();
        logic [31:0] r;
        logic        e;
        wr(`OFF_CTRL, `CTRL_RESET | 32'h2);
        status_wait(32'h80000, 32'h80000);
        status_wait(32'h80000, 32'h0);
        wr(`OFF_FAB_DELAY, 32'h15);
        apb(1'b0, `OFF_STATUS, 32'h0, r, e);
        chk(r[11:6] == 6'h15, 32'h0);
        status_wait(32'hfc0, 32'h15 << 6);
        $display("t_latch done");
    endtask : t_latch
    task automatic t_shift();
        int n;
        int x;
        x = 4 + 22 + 3 * 22;
        lag(n);
        chk(n >= x - 2 && n <= x + 2, 32'h1);
        $display("t_shift done");
    endtask : t_shift
    task automatic t_zero();
        int n;
        int k;
        logic [7:0] d;
        wr(`OFF_CTRL, `CTRL_RESET | 32'h1);
        lag(n);
        chk(n >= 2 && n <= 6, 32'h1);
        @(posedge pclk);
        chk(strobe_bus, 32'h1);
        k = 0;
        while (busy !== 1'b0 && k < 60) begin
            @(posedge pclk);
            k++;
        end
        if (busy !== 1'b0) hang();
        repeat (6) @(posedge pclk);
        // The last word lands in the high half, the one before in the low.
        d = capt_h - capt_l;
        chk(d, 32'h11);
        $display("t_zero done");
    endtask : t_zero
    task automatic t_post();
        int i;
        int c;
        @(posedge pclk);
        postamble_gate <= 1'b1;
        repeat (3) @(posedge pclk);
        read_go <= 1'b1;
        c = 0;
        for (i = 0; i < 40; i++) begin
            @(posedge pclk);
            read_go <= 1'b0;
            c += (shifted_strobe !== 1'b0);
        end
        chk(c, 32'h0);
        postamble_gate <= 1'b0;
        $display("t_post done");
    endtask : t_post
    task automatic t_write();
        int n;
        int i;
        logic sh, sl, dh, dl;
        wr(`OFF_CTRL, `CTRL_RESET);
        wr(`OFF_WDATA, 32'h3cc3);
        // Start just after a system clock fall, so the strobe enable lags
        // the data enable by two pclk cycles, less than the half-cycle preamble.
        n = 0;
        while (sys_clk !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        while (sys_clk !== 1'b0 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        if (sys_clk !== 1'b0) hang();
        write_active <= 1'b1;
        n = 0;
        while (dq_oe !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        chk(dqs_oe, 32'h0);
        n = 0;
        while (dqs_oe !== 1'b1 && n < 12) begin
            @(posedge pclk);
            n++;
        end
        chk(n >= 2 && n <= 6, 32'h1);
        {sh, sl, dh, dl} = 4'h0;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            sh |= (dqs_out === 1'b1);
            sl |= (dqs_out === 1'b0);
            dh |= (dq_out === 8'hc3);
            dl |= (dq_out === 8'h3c);
        end
        chk({sh, sl}, 32'h3);
        chk({dh, dl}, 32'h3);
        write_active <= 1'b0;
        $display("t_write done");
    endtask : t_write

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_counter();
        t_latch();
        t_shift();
        t_zero();
        t_post();
        t_write();
        finish_test();
    end
endmodule : tb_top

/* File: verilog/ddr_strobe_capture_path.sv */
`timescale 1ns/1ps
`include "strobe_params.svh"
module ddr_strobe_capture_path #(
    parameter int DQ_WIDTH   = 8,
    parameter int HIST_DEPTH = 512
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic [7:0]            paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  dqs_in,
    output logic                       dqs_out,
    output logic                       dqs_oe,
    input  wire logic [DQ_WIDTH-1:0]   dq_in,
    output logic      [DQ_WIDTH-1:0]   dq_out,
    output logic                       dq_oe,
    input  wire logic                  ref_clk,
    input  wire logic                  sys_clk,
    input  wire logic                  wr_clk,
    input  wire logic                  alt_oe_clk,
    input  wire logic                  meas_up,
    input  wire logic                  meas_dn,
    input  wire logic                  postamble_gate,
    input  wire logic                  write_active,
    output logic                       shifted_strobe,
    output logic                       strobe_bus,
    output strobe_pkg::delay_t         dll_setting,
    output logic      [DQ_WIDTH-1:0]   capt_h,
    output logic      [DQ_WIDTH-1:0]   capt_l
);
    import strobe_pkg::*;

    localparam int TAPW = $clog2(HIST_DEPTH);
    localparam int NA   = 5;

    function automatic logic [9:0] elem_delay(input logic [6:0] steps);
        elem_delay = `INTRINSIC_CYC + 10'(steps) * `STEP_CYC;
    endfunction : elem_delay

    function automatic offset_t clamp_offset(input offset_t v,
                                             input logic mode0);
        if (mode0) clamp_offset = v;
        else if (v > 7'sd31) clamp_offset = 7'sd31;
        else if (v < -7'sd32) clamp_offset = -7'sd32;
        else clamp_offset = v;
    endfunction : clamp_offset

    ////////////////////////////////////////////////////////////////////////
    // Every off-domain input passes two flops; the third stage only
    // remembers the settled level so edges can be found.

    logic [NA-1:0]       sync1, sync2, sync3;
    logic [DQ_WIDTH-1:0] dq_s1, dq_s2;
    wire  logic [NA-1:0] async_in;
    wire  logic [NA-1:0] rise, fall;

    assign async_in = {alt_oe_clk, wr_clk, sys_clk, ref_clk, dqs_in};
    assign rise     = sync2 & ~sync3;
    assign fall     = ~sync2 & sync3;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // The strobe idles high, so its stages start high: no false edge.
            sync1 <= NA'(1);
            sync2 <= NA'(1);
            sync3 <= NA'(1);
            dq_s1 <= '0;
            dq_s2 <= '0;
        end else begin
            sync1 <= async_in;
            sync2 <= sync1;
            sync3 <= sync2;
            dq_s1 <= dq_in;
            dq_s2 <= dq_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers.

    logic [12:0]             ctrl;
    delay_t                  fab_delay;
    offset_t                 offset_reg;
    logic [2*DQ_WIDTH-1:0]   wdata;
    delay_t                  lat_delay;
    offset_t                 lat_offset;
    upd_state_t              upd_state;
    logic [3:0]              upd_cnt;

    wire logic wr_en = psel & penable & pwrite;
    wire logic sel_ctrl = paddr == `OFF_CTRL;
    wire logic sel_fab  = paddr == `OFF_FAB_DELAY;
    wire logic sel_off  = paddr == `OFF_OFFSET;
    wire logic sel_stat = paddr == `OFF_STATUS;
    wire logic sel_capt = paddr == `OFF_CAPTURE;
    wire logic sel_wd   = paddr == `OFF_WDATA;
    wire logic mapped   = sel_ctrl | sel_fab | sel_off | sel_stat
                        | sel_capt | sel_wd;
    wire logic [31:0] rd_mux =
        sel_ctrl ? 32'(ctrl) :
        sel_fab  ? 32'(fab_delay) :
        sel_off  ? 32'({1'b0, offset_reg}) :
        sel_stat ? {12'h000, upd_state == UPD_OPEN, lat_offset,
                    lat_delay, dll_setting} :
        sel_capt ? 32'({capt_l, capt_h}) :
        sel_wd   ? 32'(wdata) : 32'h0000_0000;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl       <= `CTRL_RESET;
            fab_delay  <= '0;
            offset_reg <= '0;
            wdata      <= '0;
            prdata     <= '0;
        end else begin
            if (psel & ~penable) prdata <= rd_mux;
            if (wr_en & sel_ctrl) ctrl <= pwdata[12:0];
            if (wr_en & sel_fab) fab_delay <= pwdata[5:0];
            if (wr_en & sel_off) offset_reg <= pwdata[6:0];
            if (wr_en & sel_wd) wdata <= pwdata[2*DQ_WIDTH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Delay setting counter and the latched update path.

    wire logic     ref_rise = rise[1];
    wire delay_t   next_delay = ctrl[`CTRL_SRC_FABRIC] ? fab_delay
                                                       : dll_setting;
    wire offset_t  next_offset = clamp_offset(offset_reg,
                                              ctrl[`CTRL_FREQ_MODE0]);
    wire logic     upd_done = ref_rise && upd_cnt == `UPD_PERIOD - 4'h1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dll_setting <= '0;
        end else if (meas_up && !meas_dn && dll_setting != `DELAY_MAX) begin
            dll_setting <= dll_setting + 6'h01;
        end else if (meas_dn && !meas_up && dll_setting != 6'h00) begin
            dll_setting <= dll_setting - 6'h01;
        end
    end

    // The latch opens for one reference period only after a full update
    // period, so a setting in flight never reaches part of the chain.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upd_state  <= UPD_WAIT;
            upd_cnt    <= '0;
            lat_delay  <= '0;
            lat_offset <= '0;
        end else begin
            case (upd_state)
                UPD_WAIT: begin
                    if (ref_rise) upd_cnt <= upd_cnt + 4'h1;
                    if (upd_done) begin
                        upd_cnt   <= '0;
                        upd_state <= UPD_OPEN;
                    end
                end
                UPD_OPEN: begin
                    lat_delay  <= next_delay;
                    lat_offset <= next_offset;
                    if (ref_rise) upd_state <= UPD_WAIT;
                end
                default: upd_state <= UPD_WAIT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Delay chain: element one carries the optional offset.

    wire logic signed [7:0] first_sum = $signed({2'b00, lat_delay})
                                      + 8'(lat_offset);
    wire logic [6:0] first_steps = !ctrl[`CTRL_OFFSET_EN] ? 7'(lat_delay) :
                                   first_sum < 0 ? 7'h00 :
                                   7'(first_sum);
    wire logic [9:0] chain_total = elem_delay(first_steps)
                                 + 10'd3 * elem_delay(7'(lat_delay));
    wire logic [TAPW-1:0] tap = ctrl[`CTRL_ZERO_SHIFT] ? '0 :
        (chain_total > 10'(HIST_DEPTH - 1)) ? TAPW'(HIST_DEPTH - 1) :
        TAPW'(chain_total);
    logic delayed;

    strobe_delay_line #(.DEPTH(HIST_DEPTH)) u_chain (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (sync2[0]),
        .tap     (tap),
        .q       (delayed)
    );

    ////////////////////////////////////////////////////////////////////////
    // Postamble gate and capture clock.

    logic post_reg;
    logic cap_prev;
    wire logic gated = delayed & ~post_reg;
    wire logic cap = ctrl[`CTRL_INVERT] ? ~gated : gated;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            post_reg       <= 1'b0;
            shifted_strobe <= 1'b0;
            strobe_bus     <= 1'b1;
            cap_prev       <= 1'b1;
        end else begin
            post_reg       <= postamble_gate;
            shifted_strobe <= gated;
            strobe_bus     <= cap;
            cap_prev       <= cap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin elements: data pins launch on the write clock or shifted strobe,
    // the strobe pin on the system clock.

    wire logic outclk_dqs = ctrl[`CTRL_OUTCLK_DQS];
    wire logic wo_high = outclk_dqs ? gated : sync2[3];
    wire logic wo_rise = outclk_dqs ? gated & ~shifted_strobe : rise[3];
    wire logic wo_fall = outclk_dqs ? ~gated & shifted_strobe : fall[3];
    wire logic alt_edge = ctrl[`CTRL_ALT_INV] ? fall[4] : rise[4];
    wire logic b_edge = ctrl[`CTRL_BCLK_ALT] ? alt_edge : fall[2];
    logic dq_tri, dqs_tri;
    logic dqs_q;

    pin_io_element #(.WIDTH(DQ_WIDTH)) u_dq (
        .pclk      (pclk),
        .presetn   (presetn),
        .cap_rise  (cap & ~cap_prev),
        .cap_fall  (~cap & cap_prev),
        .cap_high  (cap),
        .d_in      (dq_s2),
        .cap_h     (capt_h),
        .cap_l     (capt_l),
        .out_rise  (wo_rise),
        .out_fall  (wo_fall),
        .out_high  (wo_high),
        .datain_h  (wdata[DQ_WIDTH-1:0]),
        .datain_l  (wdata[2*DQ_WIDTH-1:DQ_WIDTH]),
        .out_q     (dq_out),
        .oe_rise   (rise[3]),
        .oe_b_edge (fall[3]),
        .oe_sel    (ctrl[`CTRL_DQ_OE_DLY]),
        .oe_req    (write_active),
        .tri_high  (ctrl[`CTRL_TRI_HIGH]),
        .tri_en    (dq_tri)
    );

    pin_io_element #(.WIDTH(1)) u_dqs (
        .pclk      (pclk),
        .presetn   (presetn),
        .cap_rise  (rise[0]),
        .cap_fall  (fall[0]),
        .cap_high  (sync2[0]),
        .d_in      (sync2[0]),
        .cap_h     (),
        .cap_l     (),
        .out_rise  (rise[2]),
        .out_fall  (fall[2]),
        .out_high  (sync2[2]),
        .datain_h  (ctrl[`CTRL_DQS_DH]),
        .datain_l  (ctrl[`CTRL_DQS_DL]),
        .out_q     (dqs_q),
        .oe_rise   (rise[2]),
        .oe_b_edge (b_edge),
        .oe_sel    (ctrl[`CTRL_DQS_OE_DLY]),
        .oe_req    (write_active),
        .tri_high  (ctrl[`CTRL_TRI_HIGH]),
        .tri_en    (dqs_tri)
    );

    // Pin enables are high while driving, whatever the internal polarity.
    assign dqs_out = dqs_q;
    assign dqs_oe  = ctrl[`CTRL_TRI_HIGH] ? dqs_tri : ~dqs_tri;
    assign dq_oe   = ctrl[`CTRL_TRI_HIGH] ? dq_tri : ~dq_tri;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_wait_done;
        upd_state == UPD_WAIT && upd_done;
    endsequence
    sequence s_open_then_take;
        upd_state == UPD_OPEN ##1 lat_delay == $past(next_delay);
    endsequence

    a_update_opens:
    assert property (@(posedge pclk) disable iff (!presetn)
        s_wait_done |=> upd_state == UPD_OPEN)
        else $error("update enable failed to open");
    a_latch_takes:
    assert property (@(posedge pclk) disable iff (!presetn)
        upd_state == UPD_OPEN |-> s_open_then_take)
        else $error("latch did not take the selected setting");
    a_latch_holds:
    assert property (@(posedge pclk) disable iff (!presetn)
        upd_state == UPD_WAIT |=> $stable(lat_delay) && $stable(lat_offset))
        else $error("setting latch changed while closed");
    a_source_fabric:
    assert property (@(posedge pclk) disable iff (!presetn)
        ctrl[`CTRL_SRC_FABRIC] |-> next_delay == fab_delay)
        else $error("fabric delay source not selected");
    a_dll_counts:
    assert property (@(posedge pclk) disable iff (!presetn)
        meas_up && !meas_dn && dll_setting != `DELAY_MAX
        |=> dll_setting == $past(dll_setting) + 6'h01)
        else $error("delay counter did not count up");
    a_offset_range:
    assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl[`CTRL_FREQ_MODE0] |-> next_offset <= 7'sd31
                                  && next_offset >= -7'sd32)
        else $error("offset outside range for this mode");
    a_zero_bypass:
    assert property (@(posedge pclk) disable iff (!presetn)
        ctrl[`CTRL_ZERO_SHIFT] |-> tap == '0)
        else $error("zero shift did not bypass the chain");
    a_postamble_ground:
    assert property (@(posedge pclk) disable iff (!presetn)
        post_reg |=> !shifted_strobe)
        else $error("postamble did not ground the strobe");
    a_strobe_invert:
    assert property (@(posedge pclk) disable iff (!presetn)
        $past(ctrl[`CTRL_INVERT]) |-> strobe_bus != shifted_strobe)
        else $error("capture strobe not inverted");
endmodule : ddr_strobe_capture_path

/* File: verilog/pin_io_element.sv */
`timescale 1ns/1ps
module pin_io_element #(
    parameter int WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             cap_rise,
    input  wire logic             cap_fall,
    input  wire logic             cap_high,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] cap_h,
    output logic      [WIDTH-1:0] cap_l,
    input  wire logic             out_rise,
    input  wire logic             out_fall,
    input  wire logic             out_high,
    input  wire logic [WIDTH-1:0] datain_h,
    input  wire logic [WIDTH-1:0] datain_l,
    output logic      [WIDTH-1:0] out_q,
    input  wire logic             oe_rise,
    input  wire logic             oe_b_edge,
    input  wire logic             oe_sel,
    input  wire logic             oe_req,
    input  wire logic             tri_high,
    output logic                  tri_en
);
    logic [WIDTH-1:0] a_i, b_i, a_o, b_o;
    logic             a_oe_n, b_oe_n;
    wire logic        en_n;

    // With oe_sel set, either enable register being high keeps the pin released; with it clear, only the first.
    assign en_n = oe_sel ? (a_oe_n | b_oe_n) : a_oe_n;
    assign cap_h = a_i;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_i    <= '0;
            b_i    <= '0;
            cap_l  <= '0;
            a_o    <= '0;
            b_o    <= '0;
            out_q  <= '0;
            a_oe_n <= 1'b1;
            b_oe_n <= 1'b1;
            tri_en <= 1'b1;
        end else begin
            if (cap_rise) a_i <= d_in;
            if (cap_fall) b_i <= d_in;
            if (cap_high) cap_l <= b_i;
            if (out_rise) a_o <= datain_h;
            if (out_fall) b_o <= datain_l;
            out_q <= out_high ? a_o : b_o;
            if (oe_rise) a_oe_n <= ~oe_req;
            if (oe_b_edge) b_oe_n <= a_oe_n;
            tri_en <= tri_high ? ~en_n : en_n;
        end
    end

    a_capture_rise:
    assert property (@(posedge pclk) disable iff (!presetn)
        cap_rise |=> a_i == $past(d_in))
        else $error("first input register missed a capture rise");
    a_oe_preamble:
    assert property (@(posedge pclk) disable iff (!presetn)
        oe_sel && $fell(a_oe_n) |-> en_n)
        else $error("write preamble was not extended");
endmodule : pin_io_element

/* File: verilog/strobe_delay_line.sv */
`timescale 1ns/1ps
module strobe_delay_line #(
    parameter int DEPTH = 512
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     d,
    input  wire logic [$clog2(DEPTH)-1:0] tap,
    output logic                          q
);
    logic [DEPTH-1:0] hist;
    logic [DEPTH-1:0] next_hist;

    // Tap 0 is the newest sample, so a zero tap adds only the one-cycle output register.
    assign next_hist = {hist[DEPTH-2:0], d};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist <= '0;
            q    <= 1'b0;
        end else begin
            hist <= next_hist;
            q    <= next_hist[tap];
        end
    end
endmodule : strobe_delay_line

/* File: verilog/strobe_params.svh */
// What this block does
// - Each strobe pin has its own block: delay chain and postamble gate.
// - Chain has four elements; the pin-side one may add the phase offset.
// - Delay setting comes from the phase-measurement circuit or from fabric.
// - A zero shift bypasses the whole delay chain.
// - Element delay is intrinsic delay plus steps times step delay.
// - Delay and offset settings pass a latch so all elements change together.
// - An update enable, timed by the reference clock, opens the latches.
// - Shifted strobe clocks data capture and is also offered to fabric.
// - A registered postamble control grounds the shifted strobe after a read.
// - Pin element: two input regs, a latch, two output and two enable regs.
// - The active-low second enable register adds a half-cycle write preamble.
// - A select chooses the direct or half-cycle delayed output enable.
// - Tri-state enable is active low by default, optionally active high.
// - Second register clocks from inverted first clock, or on the strobe pin a separate clock.
// - Capture rise loads first register, fall second; latch open while high.
// - The shifted strobe is inverted before the data capture element.
// - Write data launches on a 90 degree offset clock or the shifted strobe.
// - The delay setting is six bits from an up/down counter.
// - Phase offset is -64..63 in lowest frequency mode, else -32..31.
`ifndef STROBE_PARAMS_SVH
`define STROBE_PARAMS_SVH

`define OFF_CTRL        8'h00
`define OFF_FAB_DELAY   8'h04
`define OFF_OFFSET      8'h08
`define OFF_STATUS      8'h0c
`define OFF_CAPTURE     8'h10
`define OFF_WDATA       8'h14

`define CTRL_ZERO_SHIFT 0
`define CTRL_SRC_FABRIC 1
`define CTRL_OFFSET_EN  2
`define CTRL_FREQ_MODE0 3
`define CTRL_INVERT     4
`define CTRL_OUTCLK_DQS 5
`define CTRL_DQS_OE_DLY 6
`define CTRL_DQ_OE_DLY  7
`define CTRL_TRI_HIGH   8
`define CTRL_BCLK_ALT   9
`define CTRL_ALT_INV    10
`define CTRL_DQS_DH     11
`define CTRL_DQS_DL     12
`define CTRL_RESET      13'h0850

`define DELAY_MAX       6'h3f
`define INTRINSIC_CYC   10'h001
`define STEP_CYC        10'h001
`define UPD_PERIOD      4'h8

`endif

/* File: verilog/strobe_pkg.sv */
package strobe_pkg;
    typedef logic [5:0] delay_t;
    typedef logic signed [6:0] offset_t;
    typedef enum logic [1:0] {
        UPD_WAIT = 2'b01,
        UPD_OPEN = 2'b10
    } upd_state_t;
endpackage : strobe_pkg
